// [rtl/ctf_pkg.sv]
package ctf_pkg;
   // Register pointer positions behind the single configuration address
   localparam logic [3:0] IR_ROW_FMT = 4'h0;
   localparam logic [3:0] IR_EQUALIZE = 4'h1;
   localparam logic [3:0] IR_HSYNC = 4'h2;
   localparam logic [3:0] IR_VPORCH = 4'h3;
   localparam logic [3:0] IR_LAST = 4'hE;
   localparam logic [3:0] IR_PTR_RST = 4'h0;
   // Field positions
   localparam int DBL_BIT = 7;
   localparam int ROWH_LSB = 3;
   localparam int SYNC_SEL_BIT = 2;
   localparam int BUF_LSB = 0;
   localparam int INTERLACE_BIT = 7;
   localparam int EQ_LSB = 0;
   localparam int ROW_TABLE_BIT = 7;
   localparam int HSW_LSB = 3;
   localparam int HBP_LSB = 0;
   localparam int VFP_LSB = 5;
   localparam int VBP_LSB = 0;
   localparam int ATTR_DBL_LSB = 6;
   // Values after reset; back porch code 000 is illegal, so start at 001
   localparam logic [7:0] RST_ROW_FMT = 8'h00;
   localparam logic [7:0] RST_EQUALIZE = 8'h00;
   localparam logic [7:0] RST_HSYNC = 8'h01;
   localparam logic [7:0] RST_VPORCH = 8'h00;
   // Timing steps in character clocks or scan lines
   localparam int HW = 10;
   localparam logic [HW-1:0] HSW_STEP = 10'h002;
   localparam logic [HW-1:0] HBP_STEP = 10'h004;
   localparam logic [HW-1:0] HBP_SUB = 10'h001;
   localparam logic [6:0] VFP_STEP = 7'h04;
   localparam logic [6:0] VFP_BASE = 7'h04;
   localparam logic [6:0] VBP_STEP = 7'h02;
   localparam logic [6:0] VBP_BASE = 7'h04;

   typedef enum logic [1:0] {
      BUF_INDEPENDENT, BUF_TRANSPARENT, BUF_SHARED, BUF_ROW
   } ctf_buf_e;

   typedef enum logic [1:0] {V_ACTIVE, V_FRONT, V_SYNC, V_BACK} ctf_vstate_e;

   typedef struct packed {
      logic wr;
      logic [7:0] data;
   } ctf_cfg_wr_s;

   typedef struct packed {
      logic hsync;
      logic sync_out;
      logic blank;
      logic dbl_height;
      logic dbl_width;
      logic row_table_on;
      logic row_start;
      logic [4:0] line_addr;
      logic odd_field;
   } ctf_video_s;
endpackage

// [rtl/ctf_hgen.sv]
`timescale 1ns/100ps
module ctf_hgen
   import ctf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [HW-1:0] total,
   input wire logic [HW-1:0] active,
   input wire logic [HW-1:0] sync_start,
   input wire logic [HW-1:0] sync_len,
   output logic [HW-1:0] h_cnt,
   output logic line_end,
   output logic hsync,
   output logic hblank
);
   typedef struct packed {
      logic [HW-1:0] cnt;
      logic hsync;
      logic hblank;
   } ctf_h_s;

   ctf_h_s st;
   ctf_h_s next_st;

   always_comb begin
      next_st = st;
      next_st.cnt = (st.cnt >= total - 10'h001) ? '0 : st.cnt + 10'h001;
      // Sync and blank trail the counter by one clock
      next_st.hsync = (st.cnt >= sync_start) &&
                      (st.cnt < sync_start + sync_len);
      next_st.hblank = (st.cnt >= active);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign h_cnt = st.cnt;
   assign line_end = (st.cnt >= total - 10'h001);
   assign hsync = st.hsync;
   assign hblank = st.hblank;

   logic [HW-1:0] hs_run;
   always_ff @(posedge clk) begin
      if (rst) begin
         hs_run <= '0;
      end else begin
         hs_run <= st.hsync ? hs_run + 10'h001 : '0;
      end
   end

   a_hsync_width: assert property (@(posedge clk) disable iff (rst)
      $fell(st.hsync) && $stable(sync_len) |-> hs_run == sync_len)
      else $error("hsync pulse width differs from programmed width");
endmodule

// [rtl/ctf_timing.sv]
`timescale 1ns/100ps
// Behaviour
// - Non-interlaced row height is row-height field plus one scan lines.
// - Interlaced row height is twice field plus two; code 1111 unused.
// - Sync select clear gives vertical sync, set gives composite sync.
// - Two-bit buffer mode: independent, transparent, shared, row buffer.
// - Interlace bit selects non-interlaced or interlaced timing.
// - Equalizing constant code plus one clocks; host loads half line less two sync widths, less one.
// - Horizontal sync lasts two character clocks per step, 2 to 32.
// - Back porch is four clocks per step minus one; code 000 forbidden.
// - Front porch four lines per step plus four; back two plus four.
// - Config writes walk a pointer to the last register; reset rewinds.
// - Double height/width from attribute bits; screen start top bits copied.
// - Row table enable takes effect from the next character row.
// - Low line-lock at front porch end stretches it line by line.
module ctf_timing
   import ctf_pkg::*;
#(
   parameter int V_ROWS = 24,
   parameter int H_ACTIVE = 80,
   parameter int VSYNC_LINES = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire ctf_cfg_wr_s cfg_wr,
   input wire logic master_reset,
   input wire logic screen_start_wr,
   input wire logic [7:0] screen_start_value,
   input wire logic ac_line_lock_input,
   output ctf_video_s video,
   output ctf_buf_e buffer_mode,
   output logic interlace_on
);
   generate
      if (V_ROWS < 1 || V_ROWS > 128 || H_ACTIVE < 1 || H_ACTIVE > 256 ||
          VSYNC_LINES < 1 || VSYNC_LINES > 4) begin : g_bad
         $error("ctf_timing parameter out of range");
      end
   endgenerate

   localparam logic [6:0] ROW_LAST = 7'(V_ROWS - 1);
   localparam logic [6:0] VS_LAST = 7'(VSYNC_LINES - 1);
   localparam logic [HW-1:0] ACT = HW'(H_ACTIVE);

   typedef struct packed {
      logic [7:0] ir0;
      logic [7:0] ir1;
      logic [7:0] ir2;
      logic [7:0] ir3;
      logic [1:0] attr_dbl;
      logic [3:0] ptr;
      logic [7:0] ssr_upper;
      logic ll_meta;
      logic ll_sync;
      ctf_vstate_e vst;
      logic [6:0] vcnt;
      logic [6:0] row;
      logic [4:0] scan;
      logic field;
      logic row_table_on;
      ctf_video_s out;
   } ctf_st_s;

   ctf_st_s st;
   ctf_st_s next_st;

   logic [HW-1:0] hs_len, hbp, ec_clk, half, total, sync_start;
   logic [HW-1:0] h_cnt, h_pos;
   logic line_end, hsync, hblank, ilace, row_end, composite_sync_out;
   logic [4:0] lines_row, scan_step;
   logic [6:0] vfp, vbp;

   always_comb begin
      ilace = st.ir1[INTERLACE_BIT];
      hs_len = HSW_STEP * ({6'h0, st.ir2[HSW_LSB +: 4]} + 10'h001);
      hbp = HBP_STEP * {7'h0, st.ir2[HBP_LSB +: 3]} - HBP_SUB;
      ec_clk = {3'h0, st.ir1[EQ_LSB +: 7]} + 10'h001;
      // Half line = equalizing constant plus two sync widths
      half = ec_clk + (hs_len << 1);
      total = half << 1;
      sync_start = total - hbp - hs_len;
      lines_row = ilace ? 5'({st.ir0[ROWH_LSB +: 4], 1'b0} + 5'h02)
                        : 5'({1'b0, st.ir0[ROWH_LSB +: 4]} + 5'h01);
      scan_step = ilace ? 5'h02 : 5'h01;
      vfp = VFP_STEP * {4'h0, st.ir3[VFP_LSB +: 3]} + VFP_BASE;
      vbp = VBP_STEP * {2'h0, st.ir3[VBP_LSB +: 5]} + VBP_BASE;
   end

   ctf_hgen u_hgen (
      .clk(clk),
      .rst(rst),
      .total(total),
      .active(ACT),
      .sync_start(sync_start),
      .sync_len(hs_len),
      .h_cnt(h_cnt),
      .line_end(line_end),
      .hsync(hsync),
      .hblank(hblank)
   );

   always_comb begin
      h_pos = (h_cnt >= half) ? h_cnt - half : h_cnt;
      // Serrated broad pulses in the vertical interval, else line sync
      composite_sync_out = (st.vst == V_SYNC) ? (h_pos < half - hs_len) : hsync;
      row_end = (st.scan + scan_step >= lines_row);
   end

   always_comb begin
      next_st = st;
      next_st.ll_meta = ac_line_lock_input;
      next_st.ll_sync = st.ll_meta;
      next_st.out.row_start = 1'b0;
      if (master_reset) begin
         next_st.ptr = IR_PTR_RST;
      end else if (cfg_wr.wr) begin
         case (st.ptr)
            IR_ROW_FMT: next_st.ir0 = cfg_wr.data;
            IR_EQUALIZE: next_st.ir1 = cfg_wr.data;
            IR_HSYNC: next_st.ir2 = cfg_wr.data;
            IR_VPORCH: next_st.ir3 = cfg_wr.data;
            IR_LAST: next_st.attr_dbl = cfg_wr.data[ATTR_DBL_LSB +: 2];
            default: ;
         endcase
         if (st.ptr != IR_LAST) begin
            next_st.ptr = st.ptr + 4'h1;
         end
      end
      if (screen_start_wr) begin
         next_st.ssr_upper = screen_start_value;
         if (screen_start_value != st.ssr_upper && st.ir0[DBL_BIT]) begin
            next_st.attr_dbl = screen_start_value[7:6];
         end
      end
      if (line_end) begin
         case (st.vst)
            V_ACTIVE: begin
               if (row_end) begin
                  next_st.scan = {4'h0, st.field & ilace};
                  next_st.row_table_on = st.ir2[ROW_TABLE_BIT];
                  next_st.out.row_start = 1'b1;
                  if (st.row == ROW_LAST) begin
                     next_st.vst = V_FRONT;
                     next_st.vcnt = '0;
                  end else begin
                     next_st.row = st.row + 7'h01;
                  end
               end else begin
                  next_st.scan = st.scan + scan_step;
               end
            end
            V_FRONT: begin
               if (st.vcnt >= vfp - 7'h01) begin
                  // Stretch while line lock is low
                  if (st.ll_sync) begin
                     next_st.vst = V_SYNC;
                     next_st.vcnt = '0;
                  end
               end else begin
                  next_st.vcnt = st.vcnt + 7'h01;
               end
            end
            V_SYNC: begin
               if (st.vcnt == VS_LAST) begin
                  next_st.vst = V_BACK;
                  next_st.vcnt = '0;
               end else begin
                  next_st.vcnt = st.vcnt + 7'h01;
               end
            end
            V_BACK: begin
               if (st.vcnt >= vbp - 7'h01) begin
                  next_st.vst = V_ACTIVE;
                  next_st.row = '0;
                  next_st.field = ilace ? ~st.field : 1'b0;
                  next_st.scan = {4'h0, ~st.field & ilace};
                  next_st.row_table_on = st.ir2[ROW_TABLE_BIT];
                  next_st.out.row_start = 1'b1;
               end else begin
                  next_st.vcnt = st.vcnt + 7'h01;
               end
            end
            default: next_st.vst = V_ACTIVE;
         endcase
      end
      next_st.out.hsync = hsync;
      next_st.out.sync_out = st.ir0[SYNC_SEL_BIT] ? composite_sync_out
                                                  : (st.vst == V_SYNC);
      next_st.out.blank = hblank || (st.vst != V_ACTIVE);
      next_st.out.dbl_height = st.ir0[DBL_BIT] & st.attr_dbl[1];
      next_st.out.dbl_width = st.ir0[DBL_BIT] & st.attr_dbl[0];
      next_st.out.row_table_on = st.row_table_on;
      next_st.out.line_addr = st.scan;
      next_st.out.odd_field = st.field;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         st.ir0 <= RST_ROW_FMT;
         st.ir1 <= RST_EQUALIZE;
         st.ir2 <= RST_HSYNC;
         st.ir3 <= RST_VPORCH;
         st.ptr <= IR_PTR_RST;
      end else begin
         st <= next_st;
      end
   end

   assign video = st.out;
   assign buffer_mode = ctf_buf_e'(st.ir0[BUF_LSB +: 2]);
   assign interlace_on = st.ir1[INTERLACE_BIT];

   a_ptr_rewind: assert property (@(posedge clk) disable iff (rst)
      master_reset |=> st.ptr == IR_PTR_RST)
      else $error("pointer not rewound by master reset");
   a_ptr_advance: assert property (@(posedge clk) disable iff (rst)
      cfg_wr.wr && !master_reset && st.ptr != IR_LAST
      |=> st.ptr == $past(st.ptr) + 4'h1)
      else $error("pointer did not advance on write");
   a_ptr_holds_last: assert property (@(posedge clk) disable iff (rst)
      cfg_wr.wr && !master_reset && st.ptr == IR_LAST
      ##1 cfg_wr.wr && !master_reset |=> st.ptr == IR_LAST)
      else $error("pointer left last register");
   a_row_height: assert property (@(posedge clk) disable iff (rst)
      st.vst == V_ACTIVE && !ilace |-> st.scan <= {1'b0, st.ir0[6:3]})
      else $error("scan line beyond programmed row height");
   a_ilace_height: assert property (@(posedge clk) disable iff (rst)
      st.vst == V_ACTIVE && ilace |-> st.scan <= {st.ir0[6:3], 1'b1})
      else $error("interlaced scan line beyond row height");
   a_vsync_select: assert property (@(posedge clk) disable iff (rst)
      !st.ir0[SYNC_SEL_BIT] |=> st.out.sync_out == $past(st.vst == V_SYNC))
      else $error("sync output not plain vertical sync");
   a_composite_sync_out_select: assert property (@(posedge clk) disable iff (rst)
      st.ir0[SYNC_SEL_BIT] && st.vst != V_SYNC |=> st.out.sync_out == $past(hsync))
      else $error("composite sync not following line sync");
   a_front_stretch: assert property (@(posedge clk) disable iff (rst)
      line_end && st.vst == V_FRONT && st.vcnt >= vfp - 7'h01 && !st.ll_sync
      |=> st.vst == V_FRONT)
      else $error("front porch ended while line lock low");
   a_back_porch_end: assert property (@(posedge clk) disable iff (rst)
      st.vst == V_BACK && line_end && st.vcnt == vbp - 7'h01
      |=> st.vst == V_ACTIVE && st.row == 7'h00)
      else $error("back porch did not end on programmed count");
   a_row_table_hold: assert property (@(posedge clk) disable iff (rst)
      !(line_end && ((st.vst == V_ACTIVE && row_end) || st.vst == V_BACK))
      |=> st.row_table_on == $past(st.row_table_on))
      else $error("row table mode changed inside a row");
   a_attr_copy: assert property (@(posedge clk) disable iff (rst)
      screen_start_wr && screen_start_value != st.ssr_upper &&
      st.ir0[DBL_BIT] && !(cfg_wr.wr && st.ptr == IR_LAST)
      |=> st.attr_dbl == $past(screen_start_value[7:6]))
      else $error("screen start upper bits not copied");
endmodule

// [tb/ctf_host.sv]
`timescale 1ns/100ps
module ctf_host
   import ctf_pkg::*;
(
   input wire logic clk,
   output ctf_cfg_wr_s cfg_wr,
   output logic master_reset,
   output logic ss_wr,
   output logic [7:0] ss_val,
   output logic lock
);
   initial begin
      cfg_wr = '0;
      master_reset = 1'b0;
      ss_wr = 1'b0;
      ss_val = 8'h00;
      lock = 1'b1;
   end
   // Bus shows garbage once the strobe drops
   task automatic put(input logic [7:0] d);
      @(negedge clk);
      cfg_wr <= '{wr: 1'b1, data: d};
      @(negedge clk);
      cfg_wr <= '{wr: 1'b0, data: ~d};
   endtask
   task automatic start(input logic [7:0] v);
      @(negedge clk);
      ss_wr <= 1'b1;
      ss_val <= v;
      @(negedge clk);
      ss_wr <= 1'b0;
      ss_val <= ~v;
   endtask
   task automatic set_lock(input logic v);
      @(negedge clk);
      lock <= v;
   endtask
   task automatic setup(input logic [7:0] r0, input logic il, rt,
                        input int hsc, hbc, tot, input logic [7:0] r3);
      int ec;
      ec = tot / 2 - 4 * (hsc + 1) - 1;
      @(negedge clk);
      master_reset <= 1'b1;
      @(negedge clk);
      master_reset <= 1'b0;
      put(r0);
      put({il, 7'(ec)});
      put({rt, 4'(hsc), 3'(hbc)});
      put(r3);
   endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
   import ctf_pkg::*;
   localparam int VR = 2;
   localparam int VS = 3;
   logic clk;
   logic rst;
   ctf_cfg_wr_s cfg_wr;
   logic master_reset;
   logic ss_wr;
   logic lock;
   logic [7:0] ss_val;
   ctf_video_s video;
   ctf_buf_e buffer_mode;
   logic interlace_on;
   logic [4:0] la_max;
   int num_errors = 0;
   int n_compared = 0;
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   ctf_host host(.clk(clk), .cfg_wr(cfg_wr), .master_reset(master_reset),
      .ss_wr(ss_wr), .ss_val(ss_val), .lock(lock));
   ctf_timing #(.V_ROWS(VR), .H_ACTIVE(8), .VSYNC_LINES(VS)) uut (
      .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .master_reset(master_reset),
      .screen_start_wr(ss_wr), .screen_start_value(ss_val),
      .ac_line_lock_input(lock), .video(video), .buffer_mode(buffer_mode),
      .interlace_on(interlace_on));
   always @(negedge clk) begin
      if (video.line_addr > la_max) la_max = video.line_addr;
   end
   task automatic final_report();
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %0d seen %0d", nm, e, s);
      end
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return video.hsync;
         1: return video.sync_out;
         2: return video.blank;
         default: return video.row_start;
      endcase
   endfunction
   // Cycles until signal k shows level v, at least one
   task automatic go(input int k, input logic v, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 20000) begin
            num_errors++;
            final_report();
         end
      end while (sig(k) !== v);
   endtask
   initial begin
      int rc, il, sel, hsc, hbc, hs, hbp, tot, vfc, vbc, rt, f, a, b, p, q;
      rst = 1'b1;
      void'($urandom(32'h1e1cef97));
      repeat (6) @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("buffer_mode", buffer_mode, BUF_INDEPENDENT);
      check("interlace_on", interlace_on, 1'b0);
      for (int i = 0; i < 6; i++) begin
         rc = 1 + $urandom % 7;
         il = $urandom % 2;
         sel = il ? 0 : $urandom % 2;
         hsc = $urandom % 4;
         hbc = 1 + $urandom % 7;
         vfc = $urandom % 8;
         vbc = $urandom % 8;
         rt = $urandom % 2;
         hs = 2 * (hsc + 1);
         hbp = 4 * hbc - 1;
         tot = 8 + 3 + $urandom % 6 + hs + hbp;
         tot += tot % 2;
         while (tot / 2 < 2 * hs + 1) tot += 2;
         f = (VR * (rc + 1) + 4 * vfc + 4 + VS + 2 * vbc + 4) * tot;
         host.setup({1'b0, 4'(rc), 1'(sel), 2'(i)}, 1'(il), 1'(rt), hsc,
            hbc, tot, {3'(vfc), 5'(vbc)});
         check("buffer_mode", buffer_mode, 32'(i % 4));
         check("interlace_on", interlace_on, 32'(il));
         // Start inside the frame so no vertical edge of composite sync is measured
         go(3, 1, a);
         go(1, 0, a);
         go(1, 1, a);
         la_max = 5'h00;
         go(1, 0, a);
         go(1, 1, b);
         if (sel) begin
            check("line_sync", 32'(a + b <= tot), 32'h1);
         end else begin
            if (!il) check("frame", a + b, f);
            go(1, 0, a);
            go(1, 1, b);
            check("line_addr", la_max, il ? 2 * rc + 1 : rc);
         end
         check("row_table", video.row_table_on, 32'(rt));
         go(3, 1, a);
         go(3, 0, a);
         go(3, 1, b);
         p = a + b;
         go(3, 0, a);
         go(3, 1, b);
         q = a + b;
         check("row", p < q ? p : q, (rc + 1) * tot);
         // Measure on the first line of a visible row, not in retrace
         for (int k = 0; k < 4; k++) begin
            go(3, 1, a);
            repeat (4) @(negedge clk);
            if (video.blank === 1'b0) break;
         end
         go(0, 1, a);
         go(0, 0, a);
         check("hsync", a, hs);
         go(2, 0, p);
         check("back_porch", p, hbp);
         go(0, 1, q);
         check("line", a + p + q, tot);
      end
      // Junk to unbuilt registers, then saturation on the last one
      host.setup({1'b1, 4'h1, 1'b0, 2'b10}, 1'b0, 1'b0, 0, 1, 24, 8'h00);
      repeat (10) host.put(8'hFF);
      host.put(8'hC0);
      host.put(8'h80);
      go(3, 1, a);
      repeat (3) @(negedge clk);
      check("buffer_mode", buffer_mode, BUF_SHARED);
      check("dbl_height", video.dbl_height, 1'b1);
      check("dbl_width", video.dbl_width, 1'b0);
      host.start(8'h40);
      repeat (3) @(negedge clk);
      check("dbl_height", video.dbl_height, 1'b0);
      check("dbl_width", video.dbl_width, 1'b1);
      f = (VR * 2 + 4 + VS + 4) * 24;
      go(1, 0, a);
      go(1, 1, a);
      host.set_lock(1'b0);
      repeat (f + 48) @(negedge clk);
      host.set_lock(1'b1);
      go(1, 1, b);
      p = f + 50 + b;
      check("lock", 32'(p > f && (p - f) % 24 == 0), 32'h1);
      final_report();
   end
endmodule
